// >>> logic/pwm_evt_ctrl.sv
// event, interrupt, debug and protection logic of the 12-bit pwm timer
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module pwm_evt_ctrl
  import pwm_evt_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        event_a_in,
  input  wire logic        event_b_in,
  input  wire logic [1:0]  sleep_mode,
  input  wire logic        debug_halt,
  output evt_out_t         events_out,
  output fault_t           fault_a_out,
  output fault_t           fault_b_out,
  output logic             irq
);

  typedef struct packed {
    logic              ack;
    logic [31:0]       rdata;
    logic              enable;
    logic [7:0]        evctrl_a;
    logic [7:0]        evctrl_b;
    logic [3:0]        inmode_a;
    logic [3:0]        inmode_b;
    logic [3:0]        int_en;
    logic [3:0]        flags;
    logic [7:0]        fault_ctrl;
    logic [7:0]        dly_ctrl;
    logic [7:0]        dly_val;
    logic [2:0]        dbg_ctrl;
    logic [3:0][11:0]  cmp;
    logic [11:0]       cnt;
    logic [11:0]       cap_a;
    logic [11:0]       cap_b;
    logic [2:0]        unlock_cnt;
    dly_state_t        dly_st;
    logic [7:0]        dly_cnt;
    logic [2:0]        psc_cnt;
    logic [1:0]        in_prev;
    evt_out_t          evt;
    fault_t            fault_a;
    fault_t            fault_b;
    logic              irq;
  } state_t;

  localparam state_t STATE_RST = '{
    ack: 1'b0, rdata: 32'h0000_0000, enable: 1'b0,
    evctrl_a: 8'h00, evctrl_b: 8'h00, inmode_a: 4'h0, inmode_b: 4'h0,
    int_en: 4'h0, flags: 4'h0, fault_ctrl: FAULT_CTRL_RST,
    dly_ctrl: 8'h00, dly_val: 8'h00, dbg_ctrl: 3'h0,
    cmp: {4{CMP_RST}}, cnt: 12'h000, cap_a: 12'h000, cap_b: 12'h000,
    unlock_cnt: 3'h0, dly_st: DLY_IDLE, dly_cnt: 8'h00, psc_cnt: 3'h0,
    in_prev: 2'h0, evt: '0, fault_a: '0, fault_b: '0, irq: 1'b0
  };

  state_t s_q;
  state_t s_d;

  logic [31:0] wmask;
  logic [31:0] wlane;
  logic [31:0] wm;
  logic        req;
  logic        wr;
  logic        run;
  logic        dbg_fault;
  logic        eff_a;
  logic        eff_b;
  logic        hit_a;
  logic        hit_b;
  logic        blanking;
  logic [1:0]  dly_sel;
  logic [2:0]  dly_src;
  logic [3:0]  div;
  logic [2:0]  div_m1;
  logic [3:0]  match;
  logic        src_hit;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic [31:0] rd;

  always_comb begin
    s_d       = s_q;
    req       = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr        = req & wb_we_i;
    flag_set  = 4'h0;
    flag_clr  = 4'h0;
    rd        = 32'h0000_0000;
    src_hit   = 1'b0;

    // the timer may run only outside deep sleep and outside an unpermitted halt
    run = s_q.enable & (sleep_mode <= SLEEP_IDLE)
        & ~(debug_halt & ~s_q.dbg_ctrl[DBG_RUN_BIT]);
    dbg_fault = debug_halt & s_q.dbg_ctrl[DBG_FAULT_BIT];

    dly_sel  = s_q.dly_ctrl[DLY_SEL_LSB +: 2];
    dly_src  = s_q.dly_ctrl[DLY_TRIG_LSB +: 3];
    div      = 4'h1 << s_q.dly_ctrl[DLY_PRESC_LSB +: 2];
    div_m1   = 3'(div - 4'h1);
    blanking = (dly_sel == DLY_SEL_BLANK) & (s_q.dly_st == DLY_WAIT);

    // event inputs are ignored while the blanking window runs; a debug-halt fault still gets through
    eff_a = (event_a_in & s_q.evctrl_a[EV_TRIG_EN_BIT] & ~blanking) | dbg_fault;
    eff_b = (event_b_in & s_q.evctrl_b[EV_TRIG_EN_BIT] & ~blanking) | dbg_fault;
    hit_a = eff_a & ~s_q.in_prev[0];
    hit_b = eff_b & ~s_q.in_prev[1];
    s_d.in_prev = {eff_b, eff_a};

    // edge inputs act for the detecting cycle, level inputs for as long as asserted
    s_d.fault_a.active = s_q.evctrl_a[EV_EDGE_BIT] ? hit_a : eff_a;
    s_d.fault_a.mode   = s_q.inmode_a;
    s_d.fault_b.active = s_q.evctrl_b[EV_EDGE_BIT] ? hit_b : eff_b;
    s_d.fault_b.mode   = s_q.inmode_b;

    if (hit_a && s_q.evctrl_a[EV_CAPTURE_BIT]) begin
      s_d.cap_a = s_q.cnt;
    end
    if (hit_b && s_q.evctrl_b[EV_CAPTURE_BIT]) begin
      s_d.cap_b = s_q.cnt;
    end
    flag_set[FLAG_TRIGGER_A_FLAG_BIT] = hit_a;
    flag_set[FLAG_TRIGGER_B_FLAG_BIT] = hit_b;

    // counter and compare matches; a stopped counter gives no repeated strobes
    for (int i = 0; i < 4; i++) begin
      match[i] = run & (s_q.cnt == s_q.cmp[i]);
    end
    if (run) begin
      if (match[CMP_B_CLR]) begin
        s_d.cnt = 12'h000;
        flag_set[FLAG_OVF_BIT] = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 12'h001;
      end
    end
    s_d.evt.cmp_b_clr = match[CMP_B_CLR];
    s_d.evt.cmp_a_set = match[CMP_A_SET];
    s_d.evt.cmp_b_set = match[CMP_B_SET];

    case (dly_src)
      SRC_TRIG_A: src_hit = hit_a;
      SRC_TRIG_B: src_hit = hit_b;
      3'h0, 3'h1, 3'h2, 3'h3: src_hit = match[dly_src[1:0]];
      default: src_hit = 1'b0;
    endcase

    // one delay engine serves both the event delay and the blanking window
    s_d.evt.programmable_output_event = 1'b0;
    case (s_q.dly_st)
      DLY_IDLE: begin
        if (src_hit) begin
          if (dly_sel == DLY_SEL_EVENT) begin
            s_d.dly_st  = DLY_WAIT;
            s_d.dly_cnt = 8'h00;
            s_d.psc_cnt = 3'h0;
          end else begin
            s_d.evt.programmable_output_event = 1'b1;
            if (dly_sel == DLY_SEL_BLANK) begin
              s_d.dly_st  = DLY_WAIT;
              s_d.dly_cnt = 8'h00;
              s_d.psc_cnt = 3'h0;
            end
          end
        end
      end
      DLY_WAIT: begin
        if (s_q.dly_cnt == s_q.dly_val) begin
          s_d.dly_st = DLY_IDLE;
          s_d.evt.programmable_output_event = (dly_sel == DLY_SEL_EVENT);
        end else if (s_q.psc_cnt == div_m1) begin
          s_d.psc_cnt = 3'h0;
          s_d.dly_cnt = s_q.dly_cnt + 8'h01;
        end else begin
          s_d.psc_cnt = s_q.psc_cnt + 3'h1;
        end
      end
      default: s_d.dly_st = DLY_IDLE;
    endcase

    // unlock window shrinks per cycle; a cycle-based window is stricter than an instruction count
    if (s_q.unlock_cnt != 3'h0) begin
      s_d.unlock_cnt = s_q.unlock_cnt - 3'h1;
    end

    case (wb_adr_i)
      OFS_CTRL:       rd = {31'h0, s_q.enable};
      OFS_EVCTRL_A:   rd = {24'h0, s_q.evctrl_a};
      OFS_EVCTRL_B:   rd = {24'h0, s_q.evctrl_b};
      OFS_INMODE_A:   rd = {28'h0, s_q.inmode_a};
      OFS_INMODE_B:   rd = {28'h0, s_q.inmode_b};
      OFS_INT_EN:     rd = {28'h0, s_q.int_en};
      OFS_INT_FLAGS:  rd = {28'h0, s_q.flags};
      OFS_STATUS:     rd = {15'h0, s_q.dly_st, 3'h0, run, s_q.cnt};
      OFS_FAULT_CTRL: rd = {24'h0, s_q.fault_ctrl};
      OFS_DELAY_CTRL: rd = {24'h0, s_q.dly_ctrl};
      OFS_DELAY_VAL:  rd = {24'h0, s_q.dly_val};
      OFS_DEBUG_CTRL: rd = {29'h0, s_q.dbg_ctrl};
      OFS_CMP_A_SET:  rd = {20'h0, s_q.cmp[CMP_A_SET]};
      OFS_CMP_A_CLR:  rd = {20'h0, s_q.cmp[CMP_A_CLR]};
      OFS_CMP_B_SET:  rd = {20'h0, s_q.cmp[CMP_B_SET]};
      OFS_CMP_B_CLR:  rd = {20'h0, s_q.cmp[CMP_B_CLR]};
      OFS_CAPTURE_A:  rd = {20'h0, s_q.cap_a};
      OFS_CAPTURE_B:  rd = {20'h0, s_q.cap_b};
      default:        rd = 32'h0000_0000;
    endcase

    // byte lanes with sel low keep the old register contents
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wlane = wb_dat_i & wmask;
    wm    = (rd & ~wmask) | wlane;

    // register writes land on the cycle that ack is raised
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL:       s_d.enable   = wm[0];
        OFS_EVCTRL_A:   s_d.evctrl_a = wm[7:0];
        OFS_EVCTRL_B:   s_d.evctrl_b = wm[7:0];
        OFS_INMODE_A:   s_d.inmode_a = wm[3:0];
        OFS_INMODE_B:   s_d.inmode_b = wm[3:0];
        OFS_INT_EN:     s_d.int_en   = wm[3:0] & FLAG_MASK;
        OFS_INT_FLAGS:  flag_clr     = wlane[3:0];
        OFS_DELAY_CTRL: s_d.dly_ctrl = wm[7:0];
        OFS_DELAY_VAL:  s_d.dly_val  = wm[7:0];
        OFS_DEBUG_CTRL: s_d.dbg_ctrl = wm[2:0];
        OFS_CMP_A_SET:  s_d.cmp[CMP_A_SET] = wm[11:0];
        OFS_CMP_A_CLR:  s_d.cmp[CMP_A_CLR] = wm[11:0];
        OFS_CMP_B_SET:  s_d.cmp[CMP_B_SET] = wm[11:0];
        OFS_CMP_B_CLR:  s_d.cmp[CMP_B_CLR] = wm[11:0];
        OFS_PROT_KEY: begin
          if (wb_sel_i[0] && wb_dat_i[7:0] == UNLOCK_KEY) begin
            s_d.unlock_cnt = UNLOCK_WINDOW;
          end
        end
        OFS_FAULT_CTRL: begin
          s_d.unlock_cnt = 3'h0;
          if (s_q.unlock_cnt != 3'h0) begin
            s_d.fault_ctrl = wm[7:0];
          end
        end
        default: ;
      endcase
    end

    // a flag raised in the same cycle as its clear survives
    s_d.flags = ((s_q.flags & ~flag_clr) | flag_set) & FLAG_MASK;
    s_d.irq   = |(s_d.flags & s_q.int_en);

    s_d.ack   = req;
    s_d.rdata = req ? rd : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o    = s_q.rdata;
  assign wb_ack_o    = s_q.ack;
  assign events_out  = s_q.evt;
  assign fault_a_out = s_q.fault_a;
  assign fault_b_out = s_q.fault_b;
  assign irq         = s_q.irq;

endmodule
`default_nettype wire

// >>> logic/pwm_evt_pkg.sv
// constants and types for the pwm timer event and interrupt controller
package pwm_evt_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_EVCTRL_A    = 8'h04;
  localparam logic [7:0] OFS_EVCTRL_B    = 8'h08;
  localparam logic [7:0] OFS_INMODE_A    = 8'h0C;
  localparam logic [7:0] OFS_INMODE_B    = 8'h10;
  localparam logic [7:0] OFS_INT_EN      = 8'h14;
  localparam logic [7:0] OFS_INT_FLAGS   = 8'h18;
  localparam logic [7:0] OFS_STATUS      = 8'h1C;
  localparam logic [7:0] OFS_FAULT_CTRL  = 8'h20;
  localparam logic [7:0] OFS_DELAY_CTRL  = 8'h24;
  localparam logic [7:0] OFS_DELAY_VAL   = 8'h28;
  localparam logic [7:0] OFS_DEBUG_CTRL  = 8'h2C;
  localparam logic [7:0] OFS_CMP_A_SET   = 8'h30;
  localparam logic [7:0] OFS_CMP_A_CLR   = 8'h34;
  localparam logic [7:0] OFS_CMP_B_SET   = 8'h38;
  localparam logic [7:0] OFS_CMP_B_CLR   = 8'h3C;
  localparam logic [7:0] OFS_CAPTURE_A   = 8'h40;
  localparam logic [7:0] OFS_CAPTURE_B   = 8'h44;
  localparam logic [7:0] OFS_PROT_KEY    = 8'h48;

  // field positions
  localparam int EV_TRIG_EN_BIT  = 0;
  localparam int EV_CAPTURE_BIT  = 2;
  localparam int EV_EDGE_BIT     = 4;
  localparam int FLAG_OVF_BIT    = 0;
  localparam int FLAG_TRIGGER_A_FLAG_BIT  = 2;
  localparam int FLAG_TRIGGER_B_FLAG_BIT  = 3;
  localparam int DBG_RUN_BIT     = 0;
  localparam int DBG_FAULT_BIT   = 2;
  localparam int DLY_SEL_LSB     = 0;
  localparam int DLY_TRIG_LSB    = 2;
  localparam int DLY_PRESC_LSB   = 5;

  // compare slots
  localparam int CMP_A_SET = 0;
  localparam int CMP_A_CLR = 1;
  localparam int CMP_B_SET = 2;
  localparam int CMP_B_CLR = 3;

  // delay_control select codes
  localparam logic [1:0] DLY_SEL_OFF   = 2'h0;
  localparam logic [1:0] DLY_SEL_BLANK = 2'h1;
  localparam logic [1:0] DLY_SEL_EVENT = 2'h2;

  // programmable event source codes (0..3 are compare slots)
  localparam logic [2:0] SRC_TRIG_A = 3'h4;
  localparam logic [2:0] SRC_TRIG_B = 3'h5;

  // sleep codes
  localparam logic [1:0] SLEEP_IDLE = 2'h1;

  localparam logic [3:0] FLAG_MASK      = 4'hD;
  localparam logic [7:0] UNLOCK_KEY     = 8'hA5;
  localparam logic [2:0] UNLOCK_WINDOW  = 3'h4;
  localparam logic [7:0] FAULT_CTRL_RST = 8'h00;
  localparam logic [11:0] CMP_RST       = 12'hFFF;

  typedef enum logic [0:0] {
    DLY_IDLE = 1'b0,
    DLY_WAIT = 1'b1
  } dly_state_t;

  typedef struct packed {
    logic cmp_b_clr;
    logic cmp_a_set;
    logic cmp_b_set;
    logic programmable_output_event;
  } evt_out_t;

  typedef struct packed {
    logic       active;
    logic [3:0] mode;
  } fault_t;

endpackage

// >>> sim/pwm_evt_ctrl_props.sv
// concurrent checks on the bus, event strobes and interrupt line
`timescale 1ns/10ps
`default_nettype none
module pwm_evt_ctrl_props
  import pwm_evt_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire evt_out_t    events_out,
  input wire logic        irq
);
  logic wr_q;
  always_ff @(posedge sys_clk) begin
    wr_q <= wb_cyc_i & wb_stb_i & wb_we_i;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_cmp_strobe; events_out[3:1] != 3'h0 |=> (events_out[3:1] & $past(events_out[3:1])) == 3'h0; endproperty
  a_cmp_strobe: assert property (p_cmp_strobe) else $error("match strobe too long");
  property p_prog_strobe; events_out.programmable_output_event |=> !events_out.programmable_output_event; endproperty
  a_prog_strobe: assert property (p_prog_strobe) else $error("event strobe too long");
  property p_irq_hold; $fell(irq) |-> wr_q || $past(wr_q); endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  property p_reset_quiet; $fell(rst) |-> !irq && events_out == 4'h0 && !wb_ack_o; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule
bind pwm_evt_ctrl pwm_evt_ctrl_props i_props (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .events_out(events_out), .irq(irq));
`default_nettype wire

// >>> sim/evt_net_model.sv
// event routing side: drives the input channels, counts programmable output events
`timescale 1ns/10ps
`default_nettype none
module evt_net_model
  import pwm_evt_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   rst,
  input  wire logic   fire_a,
  input  wire logic   fire_b,
  input  wire evt_out_t events_out,
  output logic        event_a_in,
  output logic        event_b_in,
  output logic [15:0] prog_count
);
  // routing adds no latency; an idle channel rests low
  assign event_a_in = fire_a;
  assign event_b_in = fire_b;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prog_count <= 16'h0;
    end else if (events_out.programmable_output_event) begin
      prog_count <= prog_count + 16'h1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/pwm_evt_ctrl_tb.sv
// self-checking bench for the pwm timer event and interrupt controller
`timescale 1ns/10ps
`default_nettype none
module pwm_evt_ctrl_tb
  import pwm_evt_pkg::*;
;
  logic        sys_clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic        debug_halt = 1'b0, fire_a = 1'b0, fire_b = 1'b0, wb_ack_o, irq, ev_a, ev_b;
  logic [7:0]  wb_adr = 8'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, rd;
  logic [1:0]  sleep_mode = 2'h0;
  logic [15:0] prog_count, pc;
  logic [11:0] c1;
  logic [4:0]  tbl [6] = '{5'h01, 5'h09, 5'h10, 5'h18, 5'h04, 5'h07};
  evt_out_t    events_out;
  fault_t      fault_a_out, fault_b_out;
  int          err_count = 0, comparisons = 0, cycles = 0, d0, db, d;
  always #25 sys_clk = ~sys_clk;
  pwm_evt_ctrl i_pwm_evt_ctrl (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .event_a_in(ev_a), .event_b_in(ev_b), .sleep_mode(sleep_mode),
    .debug_halt(debug_halt), .events_out(events_out), .fault_a_out(fault_a_out),
    .fault_b_out(fault_b_out), .irq(irq));
  evt_net_model i_evt_net_model (.sys_clk(sys_clk), .rst(rst), .fire_a(fire_a), .fire_b(fire_b),
    .events_out(events_out), .event_a_in(ev_a), .event_b_in(ev_b), .prog_count(prog_count));
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("Error %0t: timeout", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one classic cycle; ack and read data are taken at the edge that samples ack high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dt);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= dt; wb_sel <= 4'hF;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt); wb(1'b1, a, dt); endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic irq_is(input logic e);
    @(negedge sys_clk);
    chk({31'h0, irq}, {31'h0, e}, "irq");
    @(posedge sys_clk);
  endtask
  task automatic fire(input logic b);
    if (b) fire_b <= 1'b1; else fire_a <= 1'b1;
    @(posedge sys_clk);
    fire_a <= 1'b0; fire_b <= 1'b0;
  endtask
  task automatic delay_of(output int n);
    n = 0;
    fire(1'b0);
    do begin @(negedge sys_clk); n++; end while (events_out.programmable_output_event !== 1'b1 && n < 3000);
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc(OFS_CMP_A_SET, {20'h0, CMP_RST}, "cmp reset");
    rdc(8'hFC, 32'h0, "unmapped");
    wr(OFS_FAULT_CTRL, 32'h5A);
    rdc(OFS_FAULT_CTRL, 32'h0, "no key");
    wr(OFS_PROT_KEY, 32'h5A);
    wr(OFS_FAULT_CTRL, 32'h5A);
    rdc(OFS_FAULT_CTRL, 32'h0, "bad key");
    wr(OFS_PROT_KEY, {24'h0, UNLOCK_KEY});
    wr(OFS_FAULT_CTRL, 32'h5A);
    rdc(OFS_FAULT_CTRL, 32'h5A, "unlocked");
    wr(OFS_FAULT_CTRL, 32'h33);
    rdc(OFS_FAULT_CTRL, 32'h5A, "relocked");
    $display("protection test done");
    wr(OFS_CMP_A_SET, 32'h10); wr(OFS_CMP_A_CLR, 32'h20); wr(OFS_CMP_B_SET, 32'h30);
    wr(OFS_CMP_B_CLR, 32'hFF); wr(OFS_CTRL, 32'h1); wr(OFS_EVCTRL_A, 32'h1); wr(OFS_EVCTRL_B, 32'h1);
    for (int i = 0; i < 6; i++) begin
      sleep_mode <= tbl[i][4:3]; debug_halt <= tbl[i][2];
      wr(OFS_DEBUG_CTRL, {31'h0, tbl[i][1]});
      wb(1'b0, OFS_STATUS, 32'h0); c1 = rd[11:0];
      wb(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, c1 !== rd[11:0]}, {31'h0, tbl[i][0]}, "count motion");
    end
    sleep_mode <= 2'h0; debug_halt <= 1'b0;
    $display("sleep and debug test done");
    for (int s = 0; s < 4; s++) begin
      wr(OFS_DELAY_CTRL, 32'(s) << DLY_TRIG_LSB); pc = prog_count;
      repeat (300) @(posedge sys_clk);
      chk({31'h0, prog_count != pc}, 32'h1, "match source");
    end
    wr(OFS_DELAY_CTRL, 32'h10); delay_of(d0);
    wr(OFS_DELAY_VAL, 32'h0); wr(OFS_DELAY_CTRL, 32'h12); delay_of(db);
    wr(OFS_DELAY_VAL, 32'h5);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_DELAY_CTRL, 32'h12 | (32'(k) << DLY_PRESC_LSB)); delay_of(d);
      chk(d - db, 5 << k, "delay");
    end
    wr(OFS_DELAY_CTRL, 32'h71); delay_of(d);
    chk(d, d0, "blanking delay");
    wr(OFS_DELAY_CTRL, 32'h0); repeat (60) @(posedge sys_clk);
    $display("event test done");
    wr(OFS_INT_FLAGS, 32'hD); wr(OFS_INT_EN, 32'h1);
    d = 0; while (irq !== 1'b1 && d < 600) begin @(negedge sys_clk); d++; end
    chk({31'h0, irq}, 32'h1, "overflow irq");
    @(posedge sys_clk); wr(OFS_CTRL, 32'h0);
    rdc(OFS_INT_FLAGS, 32'h1, "ovf flag");
    wr(OFS_INT_FLAGS, 32'h0); irq_is(1'b1);
    wr(OFS_INT_FLAGS, 32'h1); irq_is(1'b0);
    wr(OFS_INT_EN, 32'h0); fire(1'b0);
    rdc(OFS_INT_FLAGS, 32'h4, "trig a"); irq_is(1'b0);
    wr(OFS_INT_EN, 32'hD); irq_is(1'b1);
    fire(1'b1); rdc(OFS_INT_FLAGS, 32'hC, "trig b");
    wr(OFS_INT_FLAGS, 32'h4); rdc(OFS_INT_FLAGS, 32'h8, "w1c"); irq_is(1'b1);
    wr(OFS_INT_FLAGS, 32'h8); irq_is(1'b0);
    $display("interrupt test done");
    wr(OFS_EVCTRL_A, 32'h5); wr(OFS_EVCTRL_B, 32'h5);
    wb(1'b0, OFS_STATUS, 32'h0); c1 = rd[11:0];
    fire(1'b0); rdc(OFS_CAPTURE_A, {20'h0, c1}, "capture a");
    fire(1'b1); rdc(OFS_CAPTURE_B, {20'h0, c1}, "capture b");
    $display("capture test done");
    wr(OFS_INMODE_A, 32'h3); wr(OFS_INMODE_B, 32'h5); wr(OFS_DEBUG_CTRL, 32'h4);
    debug_halt <= 1'b1; repeat (3) @(posedge sys_clk); @(negedge sys_clk);
    chk({27'h0, fault_a_out}, 32'h13, "halt fault a");
    chk({27'h0, fault_b_out}, 32'h15, "halt fault b");
    @(posedge sys_clk); debug_halt <= 1'b0; repeat (3) @(posedge sys_clk); @(negedge sys_clk);
    chk({31'h0, fault_a_out.active}, 32'h0, "fault ends");
    @(posedge sys_clk); rst <= 1'b1; repeat (2) @(posedge sys_clk); rst <= 1'b0; @(posedge sys_clk);
    rdc(OFS_INT_EN, 32'h0, "second reset");
    $display("debug and reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
